/* design/tsf_flag_bit.sv */
/*
 * One sticky flag: set by a hardware event, written by software.
 * Assumes event and write strobes are synchronous to clk.
 */
`timescale 1ns/1ns
module tsf_flag_bit (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic set_evt,
	input  wire logic wr_en,
	input  wire logic wr_val,
	output logic      flag_r
);
	// Set beats a same-cycle software clear so no event is lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
		end else if (set_evt) begin
			flag_r <= 1'b1;
		end else if (wr_en) begin
			flag_r <= wr_val;
		end
	end
endmodule

/* design/tsf_sync_edge.sv */
/*
 * Three-stage synchroniser with a polarity-selectable edge detector.
 * Assumes the pin is asynchronous to clk; the first stage feeds only the second.
 * Assumes the pin idles low, since the accepted level resets to zero.
 */
`timescale 1ns/1ns
module tsf_sync_edge (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	input  wire logic falling,
	output logic      edge_pulse
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// Synchroniser chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Accepted level moves only once stages two and three agree,
	// so a slow first stage can never yield a double pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	// One pulse when the agreed level leaves the accepted one on the selected edge
	always_comb begin
		if (falling) begin
			edge_pulse = level_r & ~s3_r & ~s2_r;
		end else begin
			edge_pulse = ~level_r & s3_r & s2_r;
		end
	end
endmodule

/* design/tsf_top.sv */
/*
 * Trap status bits, second interrupt control register and first flag
 * status register of an interrupt controller, with a mask and one
 * level interrupt. Assumes a plain register port driven on clk, and
 * trap and peripheral requests as one-cycle pulses on clk.
 */
// The register offsets and strobed register access were decided locally.
//
// Summary of operation
// - Address fault trap sets control one bit 3
// - Stack fault trap sets control one bit 2
// - Oscillator loss trap sets control one bit 1
// - Unimplemented bits read zero, ignore writes
// - Five edge polarity selects at bits 4..0
// - Select one means falling edge, zero rising
// - Flags latch on request, software read/write, reset zero
// - DMA one done sets bit 14, DMA zero bit 4
// - Converter one done sets flag bit 13
// - Serial one transmit bit 12, receive 11
// - SPI event bit 10, fault bit 9
// - Timers three, two, one: bits 8, 7, 3
// - Compare two bit 6, capture two bit 5
// - Compare one 2, capture one 1, ext0 0
`timescale 1ns/1ns
module tsf_top #(
	parameter int EXT_IRQS = tsf_pkg::NUM_EXT_IRQ
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [2:0]               reg_addr,
	input  wire logic [15:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [15:0]              reg_rdata,
	input  wire tsf_pkg::tsf_trap_s       trap_evt,
	input  wire tsf_pkg::tsf_periph_req_s periph_req,
	input  wire logic [EXT_IRQS-1:0]      ext_irq_pin,
	input  wire logic                     hold_active_in,
	output logic                          alt_vector_sel,
	output logic      [EXT_IRQS-1:0]      ext_irq_evt,
	output logic                          irq
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check: the register holds exactly five polarity bits
	if (EXT_IRQS != tsf_pkg::NUM_EXT_IRQ) begin : g_bad_width
		$error("EXT_IRQS must equal five");
	end

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0]         ctrl_one_r;
	logic [15:0]         flags_r;
	logic [15:0]         mask_r;
	logic                alt_vec_r;
	logic                hold_r;
	logic [4:0]          polarity_r;
	logic [4:0]          edge_w;
	logic [15:0]         flag_set;
	logic                wr_ctrl_one;
	logic                wr_ctrl_two;
	logic                wr_flags;
	logic                wr_mask;
	logic [15:0]         rdata_nxt;

	assign wr_ctrl_one = reg_wr && (reg_addr == tsf_pkg::OFS_CTRL_ONE);
	assign wr_ctrl_two = reg_wr && (reg_addr == tsf_pkg::OFS_CTRL_TWO);
	assign wr_flags    = reg_wr && (reg_addr == tsf_pkg::OFS_FLAGS_ZERO);
	assign wr_mask     = reg_wr && (reg_addr == tsf_pkg::OFS_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////
	// External interrupt edge detectors
	for (genvar i = 0; i < 5; i++) begin : g_ext
		tsf_sync_edge u_edge (
			.clk        (clk),
			.rst_n      (rst_n),
			.pin        (ext_irq_pin[i]),
			.falling    (polarity_r[i]),
			.edge_pulse (edge_w[i])
		);
	end

	// Edge pulses handed to the rest of the controller, registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_irq_evt <= '0;
		end else begin
			ext_irq_evt <= edge_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag set sources mapped to bit positions
	always_comb begin
		flag_set                       = '0;
		flag_set[tsf_pkg::BIT_DMA1]    = periph_req.dma1;
		flag_set[tsf_pkg::BIT_DMA0]    = periph_req.dma0;
		flag_set[tsf_pkg::BIT_ADC1]    = periph_req.adc1;
		flag_set[tsf_pkg::BIT_U1TX]    = periph_req.u1tx;
		flag_set[tsf_pkg::BIT_U1RX]    = periph_req.u1rx;
		flag_set[tsf_pkg::BIT_SPI_EVT] = periph_req.spi_evt;
		flag_set[tsf_pkg::BIT_SPI_FLT] = periph_req.spi_flt;
		flag_set[tsf_pkg::BIT_TMR3]    = periph_req.tmr3;
		flag_set[tsf_pkg::BIT_TMR2]    = periph_req.tmr2;
		flag_set[tsf_pkg::BIT_TMR1]    = periph_req.tmr1;
		flag_set[tsf_pkg::BIT_OC2]     = periph_req.oc2;
		flag_set[tsf_pkg::BIT_IC2]     = periph_req.ic2;
		flag_set[tsf_pkg::BIT_OC1]     = periph_req.oc1;
		flag_set[tsf_pkg::BIT_IC1]     = periph_req.ic1;
		flag_set[tsf_pkg::BIT_EXT0]    = edge_w[0];
	end

	// Implemented flags only; bit 15 has no storage and reads zero
	for (genvar b = 0; b < 15; b++) begin : g_flag
		tsf_flag_bit u_flag (
			.clk     (clk),
			.rst_n   (rst_n),
			.set_evt (flag_set[b]),
			.wr_en   (wr_flags),
			.wr_val  (reg_wdata[b]),
			.flag_r  (flags_r[b])
		);
	end
	assign flags_r[15] = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Trap status bits; set wins over a software write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_one_r <= tsf_pkg::REG_RESET;
		end else begin
			if (wr_ctrl_one) begin
				ctrl_one_r <= reg_wdata & tsf_pkg::CTRL_ONE_MASK;
			end
			if (trap_evt.addr_fault) begin
				ctrl_one_r[tsf_pkg::BIT_ADDR_FAULT] <= 1'b1;
			end
			if (trap_evt.stack_fault) begin
				ctrl_one_r[tsf_pkg::BIT_STACK_FAULT] <= 1'b1;
			end
			if (trap_evt.osc_loss) begin
				ctrl_one_r[tsf_pkg::BIT_OSC_LOSS] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register two: vector select and polarity selects
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_vec_r  <= 1'b0;
			polarity_r <= 5'h00;
		end else if (wr_ctrl_two) begin
			alt_vec_r  <= reg_wdata[tsf_pkg::BIT_ALT_VECTOR];
			polarity_r <= reg_wdata[4:0];
		end
	end

	// Hold status mirrors the core, software cannot write it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 1'b0;
		end else begin
			hold_r <= hold_active_in;
		end
	end

	// Interrupt mask, same layout as the flag register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= tsf_pkg::REG_RESET;
		end else if (wr_mask) begin
			mask_r <= reg_wdata & tsf_pkg::FLAGS_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 16'h0000;
		unique case (reg_addr)
			tsf_pkg::OFS_CTRL_ONE: begin
				rdata_nxt = ctrl_one_r & tsf_pkg::CTRL_ONE_MASK;
			end
			tsf_pkg::OFS_CTRL_TWO: begin
				rdata_nxt = {alt_vec_r, hold_r, 9'h000, polarity_r};
			end
			tsf_pkg::OFS_FLAGS_ZERO: begin
				rdata_nxt = flags_r;
			end
			tsf_pkg::OFS_IRQ_MASK: begin
				rdata_nxt = mask_r;
			end
			default: begin
				rdata_nxt = 16'h0000;
			end
		endcase
	end

	// Read data held only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq            <= 1'b0;
			alt_vector_sel <= 1'b0;
		end else begin
			irq            <= |(flags_r & mask_r);
			alt_vector_sel <= alt_vec_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions: trap status bits
	addr_trap_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		trap_evt.addr_fault |=> ctrl_one_r[tsf_pkg::BIT_ADDR_FAULT])
		else $error("address trap bit not set");
	stack_trap_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		trap_evt.stack_fault |=> ctrl_one_r[tsf_pkg::BIT_STACK_FAULT])
		else $error("stack trap bit not set");
	osc_trap_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		trap_evt.osc_loss |=> ctrl_one_r[tsf_pkg::BIT_OSC_LOSS])
		else $error("oscillator trap bit not set");
	// A trap bit only falls through a software write
	trap_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
		!wr_ctrl_one |=> ($past(ctrl_one_r) & ~ctrl_one_r) == 16'h0000)
		else $error("trap bit lost without a write");
	trap_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl_one && !(|trap_evt)
			|=> ctrl_one_r == ($past(reg_wdata) & tsf_pkg::CTRL_ONE_MASK))
		else $error("trap bits differ from written value");

	////////////////////////////////////////////////////////////////////////
	// Assertions: register port read side
	unimpl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(reg_rd) |-> (reg_rdata[15] == 1'b0 || $past(reg_addr) != 3'h2))
		else $error("unimplemented flag bit read nonzero");
	ctrl_two_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == tsf_pkg::OFS_CTRL_TWO |=> reg_rdata[13:5] == 9'h000)
		else $error("control two reserved bits nonzero");
	unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr > tsf_pkg::OFS_IRQ_MASK |=> reg_rdata == 16'h0000)
		else $error("unmapped address read nonzero");
	ctrl_one_rsv_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == tsf_pkg::OFS_CTRL_ONE
			|=> (reg_rdata & ~tsf_pkg::CTRL_ONE_MASK) == 16'h0000)
		else $error("control one reserved bits nonzero");
	hold_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == tsf_pkg::OFS_CTRL_TWO
			|=> reg_rdata[tsf_pkg::BIT_HOLD_ACT] == $past(hold_r))
		else $error("hold status read wrong");
	pol_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == tsf_pkg::OFS_CTRL_TWO
			|=> reg_rdata[4:0] == $past(polarity_r))
		else $error("polarity selects read wrong");
	flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == tsf_pkg::OFS_FLAGS_ZERO
			|=> reg_rdata == $past(flags_r))
		else $error("flag read data wrong");
	// Read data stand one cycle only, zero otherwise
	rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data without a read strobe");

	////////////////////////////////////////////////////////////////////////
	// Assertions: control two, mask and outputs
	pol_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl_two |=> polarity_r == $past(reg_wdata[4:0]))
		else $error("polarity select not stored");
	alt_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl_two |=> alt_vec_r == $past(reg_wdata[tsf_pkg::BIT_ALT_VECTOR]))
		else $error("vector select not stored");
	hold_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl_two |=> hold_r == $past(hold_active_in))
		else $error("hold status changed by a write");
	alt_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl_two
			|=> ##1 alt_vector_sel == $past(reg_wdata[tsf_pkg::BIT_ALT_VECTOR], 2))
		else $error("vector select output wrong");
	mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_mask |=> mask_r == ($past(reg_wdata) & tsf_pkg::FLAGS_MASK))
		else $error("mask not stored");
	irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
		(|(flags_r & mask_r)) |=> irq)
		else $error("interrupt not raised for unmasked flag");
	irq_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(|(flags_r & mask_r)) |=> !irq)
		else $error("interrupt raised with no unmasked flag");
	ext_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		|edge_w |=> (edge_w & $past(edge_w)) == 5'h00)
		else $error("edge pulse longer than one cycle");

	////////////////////////////////////////////////////////////////////////
	// Assertions: every request lands in its own flag one cycle later
	ext0_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		edge_w[0] |=> flags_r[tsf_pkg::BIT_EXT0])
		else $error("external 0 flag not set");
	dma_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.dma1 |=> flags_r[tsf_pkg::BIT_DMA1])
		else $error("dma1 flag not set");
	dma0_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.dma0 |=> flags_r[tsf_pkg::BIT_DMA0])
		else $error("dma0 flag not set");
	adc_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.adc1 |=> flags_r[tsf_pkg::BIT_ADC1])
		else $error("converter flag not set");
	tx_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.u1tx |=> flags_r[tsf_pkg::BIT_U1TX])
		else $error("serial transmit flag not set");
	rx_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.u1rx |=> flags_r[tsf_pkg::BIT_U1RX])
		else $error("serial receive flag not set");
	spi_event_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.spi_evt |=> flags_r[tsf_pkg::BIT_SPI_EVT])
		else $error("spi event flag not set");
	spi_fault_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.spi_flt |=> flags_r[tsf_pkg::BIT_SPI_FLT])
		else $error("spi fault flag not set");
	tmr3_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.tmr3 |=> flags_r[tsf_pkg::BIT_TMR3])
		else $error("timer three flag not set");
	tmr2_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.tmr2 |=> flags_r[tsf_pkg::BIT_TMR2])
		else $error("timer two flag not set");
	tmr1_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.tmr1 |=> flags_r[tsf_pkg::BIT_TMR1])
		else $error("timer one flag not set");
	oc2_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.oc2 |=> flags_r[tsf_pkg::BIT_OC2])
		else $error("compare two flag not set");
	ic2_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.ic2 |=> flags_r[tsf_pkg::BIT_IC2])
		else $error("capture two flag not set");
	oc1_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.oc1 |=> flags_r[tsf_pkg::BIT_OC1])
		else $error("compare one flag not set");
	ic1_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		periph_req.ic1 |=> flags_r[tsf_pkg::BIT_IC1])
		else $error("capture one flag not set");
	flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
		!wr_flags
			|=> flags_r == (($past(flags_r) | $past(flag_set)) & tsf_pkg::FLAGS_MASK))
		else $error("flag changed without write or request");
	flag_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_flags
			|=> flags_r == (($past(reg_wdata) | $past(flag_set)) & tsf_pkg::FLAGS_MASK))
		else $error("flag write or same-cycle set wrong");
endmodule

/* inc/tsf_pkg.sv */
/*
 * Package for the trap status and interrupt flag slice: register offsets,
 * bit positions, reset values and the packed carriers shared by the files.
 * Assumes a plain 16-bit register port with one-cycle read latency.
 */
package tsf_pkg;

	// Register offsets on the plain register port
	localparam logic [2:0] OFS_CTRL_ONE   = 3'h0;
	localparam logic [2:0] OFS_CTRL_TWO   = 3'h1;
	localparam logic [2:0] OFS_FLAGS_ZERO = 3'h2;
	localparam logic [2:0] OFS_IRQ_MASK   = 3'h3;

	// Control register one bit positions
	localparam int BIT_ADDR_FAULT = 3;
	localparam int BIT_STACK_FAULT = 2;
	localparam int BIT_OSC_LOSS   = 1;

	// Control register two bit positions
	localparam int BIT_ALT_VECTOR = 15;
	localparam int BIT_HOLD_ACT   = 14;
	localparam int NUM_EXT_IRQ    = 5;

	// Flag register bit positions
	localparam int BIT_DMA1    = 14;
	localparam int BIT_ADC1    = 13;
	localparam int BIT_U1TX    = 12;
	localparam int BIT_U1RX    = 11;
	localparam int BIT_SPI_EVT = 10;
	localparam int BIT_SPI_FLT = 9;
	localparam int BIT_TMR3    = 8;
	localparam int BIT_TMR2    = 7;
	localparam int BIT_OC2     = 6;
	localparam int BIT_IC2     = 5;
	localparam int BIT_DMA0    = 4;
	localparam int BIT_TMR1    = 3;
	localparam int BIT_OC1     = 2;
	localparam int BIT_IC1     = 1;
	localparam int BIT_EXT0    = 0;

	// Writable and implemented masks, reset values
	localparam logic [15:0] CTRL_ONE_MASK  = 16'h000e;
	localparam logic [15:0] FLAGS_MASK     = 16'h7fff;
	localparam logic [15:0] REG_RESET      = 16'h0000;

	// Peripheral request lines, one bit per flag position from 14 down to 1
	typedef struct packed {
		logic dma1;
		logic adc1;
		logic u1tx;
		logic u1rx;
		logic spi_evt;
		logic spi_flt;
		logic tmr3;
		logic tmr2;
		logic oc2;
		logic ic2;
		logic dma0;
		logic tmr1;
		logic oc1;
		logic ic1;
	} tsf_periph_req_s;

	// Trap events from the core
	typedef struct packed {
		logic addr_fault;
		logic stack_fault;
		logic osc_loss;
	} tsf_trap_s;

endpackage

/* testbench/test_tsf_top.sv */
/*
 * Self-checking bench for tsf_top: event flags, traps, reserved bits,
 * edge polarity, mask, interrupt level and reset.
 * Assumes the partner model relays requests one cycle late.
 */
`timescale 1ns/1ns
module test_tsf_top;
	typedef struct {int src; logic [2:0] adr; logic [15:0] exp; logic irq;} tsf_row_s;
	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic [2:0]               reg_addr = '0;
	logic [15:0]              reg_wdata = '0;
	logic                     reg_wr = 1'b0;
	logic                     reg_rd = 1'b0;
	logic [16:0]              req = '0;
	logic [4:0]               pin_lvl = '0;
	logic                     hold_in = 1'b0;
	logic [15:0]              reg_rdata;
	tsf_pkg::tsf_trap_s       trap_evt;
	tsf_pkg::tsf_periph_req_s periph_req;
	logic [4:0]               pins;
	logic                     alt_vec;
	logic [4:0]               ext_evt;
	logic                     irq;
	int                       n_mismatch = 0;
	int                       comparisons = 0;
	// Source index, register, expected word, expected irq
	tsf_row_s rows [17] = '{
		'{0, 3'h2, 16'h0002, 1'b1}, '{1, 3'h2, 16'h0004, 1'b1},
		'{2, 3'h2, 16'h0008, 1'b1}, '{6, 3'h2, 16'h0080, 1'b1},
		'{7, 3'h2, 16'h0100, 1'b1},
		'{3, 3'h2, 16'h0010, 1'b1}, '{13, 3'h2, 16'h4000, 1'b1},
		'{4, 3'h2, 16'h0020, 1'b1}, '{5, 3'h2, 16'h0040, 1'b1},
		'{8, 3'h2, 16'h0200, 1'b1}, '{9, 3'h2, 16'h0400, 1'b1},
		'{10, 3'h2, 16'h0800, 1'b1}, '{11, 3'h2, 16'h1000, 1'b1},
		'{12, 3'h2, 16'h2000, 1'b1},
		'{14, 3'h0, 16'h0002, 1'b0},
		'{15, 3'h0, 16'h0004, 1'b0},
		'{16, 3'h0, 16'h0008, 1'b0}
	};

	////////////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #5 clk = ~clk;

	tsf_src_model src_u (.clk(clk), .req(req), .pin_lvl(pin_lvl), .trap_evt(trap_evt),
		.periph_req(periph_req), .pins(pins));

	tsf_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trap_evt(trap_evt),
		.periph_req(periph_req), .ext_irq_pin(pins), .hold_active_in(hold_in),
		.alt_vector_sel(alt_vec), .ext_irq_evt(ext_evt), .irq(irq));

	////////////////////////////////////////////////////////////////////////////
	// Compare, bus cycles, edge probe, verdict
	task automatic chk(string what, logic [15:0] e, logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic wr(logic [2:0] a, logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [2:0] a, string what, logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(what, e, reg_rdata);
	endtask

	// Synchroniser lag is a few cycles, so watch eight
	task automatic ext_try(int i, logic lvl, logic e);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		pin_lvl[i] <= lvl;
		repeat (8) begin
			@(posedge clk);
			#1 seen = seen | ext_evt[i];
		end
		chk("ext_evt", {15'h0, e}, {15'h0, seen});
	endtask

	// Request and software clear meet at one edge; the request must win
	task automatic clash(int src, logic [2:0] a);
		@(posedge clk);
		req <= 17'h1 << src;
		@(posedge clk);
		req <= '0;
		reg_addr <= a;
		reg_wdata <= 16'h0000;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wr(3'h3, 16'h7fff);
		foreach (rows[k]) begin
			@(posedge clk);
			req <= 17'h1 << rows[k].src;
			@(posedge clk);
			req <= '0;
			repeat (3) @(posedge clk);
			rd(rows[k].adr, "flag", rows[k].exp);
			chk("irq", {15'h0, rows[k].irq}, {15'h0, irq});
			wr(rows[k].adr, 16'h0000);
		end
		// Reserved places read zero whatever is written
		wr(3'h0, 16'hffff);
		rd(3'h0, "ctrl1", 16'h000e);
		wr(3'h2, 16'hffff);
		rd(3'h2, "flags", 16'h7fff);
		chk("irq", 16'h0001, {15'h0, irq});
		wr(3'h1, 16'hffff);
		rd(3'h1, "ctrl2", 16'h801f);
		chk("alt_vec", 16'h0001, {15'h0, alt_vec});
		wr(3'h3, 16'h0000);
		rd(3'h5, "unmapped", 16'h0000);
		chk("irq", 16'h0000, {15'h0, irq});
		// Hold status is read-only: a write of zero leaves it
		@(posedge clk);
		hold_in <= 1'b1;
		wr(3'h1, 16'h0000);
		rd(3'h1, "hold", 16'h4000);
		@(posedge clk);
		hold_in <= 1'b0;
		wr(3'h2, 16'h0000);
		// Each input on each polarity, right and wrong edge
		for (int i = 0; i < 5; i++) begin
			wr(3'h1, 16'h0000);
			ext_try(i, 1'b1, 1'b1);
			ext_try(i, 1'b0, 1'b0);
			wr(3'h1, 16'h0001 << i);
			ext_try(i, 1'b1, 1'b0);
			ext_try(i, 1'b0, 1'b1);
		end
		rd(3'h2, "ext0 flag", 16'h0001);
		// A write of zero meeting a request keeps only the new bit
		clash(13, 3'h2);
		rd(3'h2, "clash flag", 16'h4000);
		clash(16, 3'h0);
		rd(3'h0, "clash trap", 16'h0008);
		// Second reset in mid-run clears everything
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 4; a++) begin
			rd(a[2:0], "reset", 16'h0000);
		end
		chk("alt_vec", 16'h0000, {15'h0, alt_vec});
		results();
	end

	// Watchdog well beyond the few hundred cycles needed
	initial begin
		#100000;
		n_mismatch++;
		results();
	end
endmodule

/* testbench/tsf_src_model.sv */
/*
 * Partner model: peripheral request sources, core traps and pins.
 * Assumes the bench asks for requests on clk; pulses last one cycle.
 */
`timescale 1ns/1ns
module tsf_src_model (
	input  wire logic                clk,
	input  wire logic [16:0]         req,
	input  wire logic [4:0]          pin_lvl,
	output tsf_pkg::tsf_trap_s       trap_evt,
	output tsf_pkg::tsf_periph_req_s periph_req,
	output logic      [4:0]          pins
);
	logic [16:0] req_r = '0;

	// Sources raise a request one cycle after being told to
	always @(posedge clk) begin
		req_r <= req;
	end

	// Zero from time zero, so reset sees no unknown
	assign {trap_evt, periph_req} = req_r;
	assign pins = pin_lvl;
endmodule
